// [qdac_consts.svh]
// Offsets, field positions, reset values and frame constants of the DAC port
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define QDAC_CODE_AB_OFS 8'h00
`define QDAC_CODE_CD_OFS 8'h04
`define QDAC_STATUS_OFS 8'h08
`define QDAC_CTRL_OFS 8'h0C
`define QDAC_FRAME_OFS 8'h10

// ****************************************
// Field positions
// ****************************************
`define QDAC_LO_CODE_LSB 0
`define QDAC_HI_CODE_LSB 16
`define QDAC_ST_PD_BIT 0
`define QDAC_ST_TERM_LSB 1
`define QDAC_ST_WRITTEN_BIT 3
`define QDAC_ST_BUSY_BIT 4
`define QDAC_ST_FCNT_LSB 8
`define QDAC_ST_ACNT_LSB 16
`define QDAC_CTRL_EN_BIT 0

// ****************************************
// Reset values and frame figures
// ****************************************
`define QDAC_CTRL_EN_RST 1'b1
`define QDAC_CODE_RST 10'h000
`define QDAC_TERM_RST 2'h3
`define QDAC_TERM_NONE 2'h0
`define QDAC_TERM_HIZ 2'h3
`define QDAC_CNT_RST 8'h00
`define QDAC_BIT_RST 4'h0
`define QDAC_LAST_BIT 4'hF
`define QDAC_SCLK_MAX_MHZ 40

`endif

// [qdac_host_model.sv]
// Host serial master model driving the DAC frame port
`timescale 1ns/1ps

module qdac_host_model (
   // Serial pins
   output logic sclk,
   output logic frame_sel_n,
   output logic sdin
);
   // ****************************************
   // Idle: clock parked high, select high
   // ****************************************
   initial begin
      sclk = 1'b1;
      frame_sel_n = 1'b1;
      sdin = 1'b0;
   end

   // Odd start offset keeps the link out of phase with hclk
   task automatic send(input logic [15:0] frame, input int nbits);
      // Step off the bench clock edge before touching the pins
      #1.3;
      frame_sel_n = 1'b0;
      #80.3;
      for (int i = 0; i < nbits; i++) begin
         sclk = 1'b1;
         sdin = (i < 16) ? frame[15-i] : ~sdin;
         #80;
         sclk = 1'b0;
         #80;
      end
      sclk = 1'b1;
      #80;
      // Released data line shows no stale value
      sdin = ~sdin;
      frame_sel_n = 1'b1;
      #240;
   endtask : send
endmodule : qdac_host_model

// [qdac_pkg.sv]
// Types shared by the quad DAC serial frame port
package qdac_pkg;

   // ****************************************
   // Frame layout, most significant bit first
   // ****************************************
   typedef struct packed {
      logic [1:0] chan;
      logic [1:0] mode;
      logic [9:0] code;
      logic [1:0] term;
   } qdac_frame_t;

   typedef enum logic [1:0] {
      QDAC_MODE_ONE = 2'h0,
      QDAC_MODE_ALL = 2'h1,
      QDAC_MODE_PD = 2'h2,
      QDAC_MODE_RSVD = 2'h3
   } qdac_mode_t;

   typedef enum {
      QDAC_ST_IDLE,
      QDAC_ST_SHIFT,
      QDAC_ST_DONE
   } qdac_state_t;

endpackage : qdac_pkg

// [qdac_serial_top.sv]
// Quad DAC serial frame input port with AHB-Lite status and control
`timescale 1ns/1ps
`include "qdac_consts.svh"

module qdac_serial_top #(
   parameter int CHANNELS = 4
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Serial pins
   input wire logic sclk,
   input wire logic frame_sel_n,
   input wire logic sdin,
   // Converter state
   output logic [CHANNELS-1:0][9:0] chan_code,
   output logic power_down,
   output logic [1:0] term_sel,
   output logic frame_applied
);

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic sclk_s1, sclk_s2, sclk_s3;
   logic fs_s1, fs_s2, fs_s3;
   logic din_s1, din_s2;

   // Data path two stages deep, level with sclk_s2 where the falling edge is seen, so they stay aligned
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // Idle level of the pin, so release shows no false edge
         sclk_s1 <= 1'b1;
         sclk_s2 <= 1'b1;
         sclk_s3 <= 1'b1;
         fs_s1 <= 1'b1;
         fs_s2 <= 1'b1;
         fs_s3 <= 1'b1;
         din_s1 <= 1'b0;
         din_s2 <= 1'b0;
      end else begin
         sclk_s1 <= sclk;
         sclk_s2 <= sclk_s1;
         sclk_s3 <= sclk_s2;
         fs_s1 <= frame_sel_n;
         fs_s2 <= fs_s1;
         fs_s3 <= fs_s2;
         din_s1 <= sdin;
         din_s2 <= din_s1;
      end
   end

   logic sclk_fall, fs_fall, fs_rise;
   assign sclk_fall = sclk_s3 & ~sclk_s2;
   assign fs_fall = fs_s3 & ~fs_s2;
   assign fs_rise = ~fs_s3 & fs_s2;

   // ****************************************
   // Frame sequencer
   // ****************************************
   qdac_pkg::qdac_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [15:0] shreg_reg;
   logic ctrl_en_reg;
   logic apply, abort;
   qdac_pkg::qdac_frame_t frame_next;

   assign apply = (state_reg == qdac_pkg::QDAC_ST_SHIFT) && !fs_s2 &&
      sclk_fall && (bit_cnt_reg == `QDAC_LAST_BIT);
   assign abort = (state_reg == qdac_pkg::QDAC_ST_SHIFT) && fs_rise;
   // Last bit taken straight from the data synchroniser (din_s2) so the frame applies on its edge
   assign frame_next = qdac_pkg::qdac_frame_t'({shreg_reg[14:0], din_s2});

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= qdac_pkg::QDAC_ST_IDLE;
      end else begin
         case (state_reg)
            qdac_pkg::QDAC_ST_IDLE: begin
               if (fs_fall && ctrl_en_reg) begin
                  state_reg <= qdac_pkg::QDAC_ST_SHIFT;
               end
            end
            qdac_pkg::QDAC_ST_SHIFT: begin
               if (fs_s2) begin
                  state_reg <= qdac_pkg::QDAC_ST_IDLE;
               end else if (apply) begin
                  state_reg <= qdac_pkg::QDAC_ST_DONE;
               end
            end
            qdac_pkg::QDAC_ST_DONE: begin
               // Edges ignored until frame-select goes high again
               if (fs_s2) begin
                  state_reg <= qdac_pkg::QDAC_ST_IDLE;
               end
            end
            default: begin
               state_reg <= qdac_pkg::QDAC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_cnt_reg <= `QDAC_BIT_RST;
         shreg_reg <= 16'h0000;
      end else if (state_reg != qdac_pkg::QDAC_ST_SHIFT) begin
         bit_cnt_reg <= `QDAC_BIT_RST;
      end else if (sclk_fall && !fs_s2) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         shreg_reg <= {shreg_reg[14:0], din_s2};
      end
   end

   // ****************************************
   // Converter state
   // ****************************************
   logic [CHANNELS-1:0][9:0] code_reg;
   logic written_reg;

   generate
      for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               code_reg[ch] <= `QDAC_CODE_RST;
            end else if (apply) begin
               if (frame_next.mode == qdac_pkg::QDAC_MODE_ALL) begin
                  code_reg[ch] <= frame_next.code;
               end else if (frame_next.mode == qdac_pkg::QDAC_MODE_ONE &&
                            frame_next.chan == 2'(ch)) begin
                  code_reg[ch] <= frame_next.code;
               end
            end
         end
      end
   endgenerate

   logic pd_reg;
   logic [1:0] term_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pd_reg <= 1'b0;
         term_reg <= `QDAC_TERM_RST;
      end else if (apply) begin
         if (frame_next.mode == qdac_pkg::QDAC_MODE_PD) begin
            pd_reg <= 1'b1;
            // Unused termination code falls back to high impedance
            term_reg <= (frame_next.term == `QDAC_TERM_NONE) ?
               `QDAC_TERM_HIZ : frame_next.term;
         end else if (frame_next.mode != qdac_pkg::QDAC_MODE_RSVD) begin
            pd_reg <= 1'b0;
         end
      end
   end

   logic [7:0] fcnt_reg, acnt_reg;
   logic [15:0] last_frame_reg;
   logic applied_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fcnt_reg <= `QDAC_CNT_RST;
         acnt_reg <= `QDAC_CNT_RST;
         last_frame_reg <= 16'h0000;
         written_reg <= 1'b0;
         applied_reg <= 1'b0;
      end else begin
         applied_reg <= apply;
         if (apply) begin
            fcnt_reg <= fcnt_reg + 8'h01;
            last_frame_reg <= frame_next;
            written_reg <= 1'b1;
         end
         if (abort) begin
            acnt_reg <= acnt_reg + 8'h01;
         end
      end
   end

   assign chan_code = code_reg;
   assign power_down = pd_reg;
   assign term_sel = term_reg;
   assign frame_applied = applied_reg;

   // ****************************************
   // AHB-Lite slave, zero wait states
   // ****************************************
   logic ahb_take;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rd_next;
   logic ctrl_view;

   assign ahb_take = hsel && htrans[1] && hready;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= ahb_take && hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_en_reg <= `QDAC_CTRL_EN_RST;
      end else if (wr_pend_reg && wr_addr_reg == `QDAC_CTRL_OFS) begin
         ctrl_en_reg <= hwdata[`QDAC_CTRL_EN_BIT];
      end
   end

   // Read right after a control write sees the new value
   assign ctrl_view = (wr_pend_reg && wr_addr_reg == `QDAC_CTRL_OFS) ?
      hwdata[`QDAC_CTRL_EN_BIT] : ctrl_en_reg;

   always_comb begin
      rd_next = 32'h0000_0000;
      case (haddr[7:0])
         `QDAC_CODE_AB_OFS: begin
            rd_next[`QDAC_LO_CODE_LSB +: 10] = code_reg[0];
            rd_next[`QDAC_HI_CODE_LSB +: 10] = code_reg[1];
         end
         `QDAC_CODE_CD_OFS: begin
            rd_next[`QDAC_LO_CODE_LSB +: 10] = code_reg[2];
            rd_next[`QDAC_HI_CODE_LSB +: 10] = code_reg[3];
         end
         `QDAC_STATUS_OFS: begin
            rd_next[`QDAC_ST_PD_BIT] = pd_reg;
            rd_next[`QDAC_ST_TERM_LSB +: 2] = term_reg;
            rd_next[`QDAC_ST_WRITTEN_BIT] = written_reg;
            rd_next[`QDAC_ST_BUSY_BIT] =
               (state_reg == qdac_pkg::QDAC_ST_SHIFT);
            rd_next[`QDAC_ST_FCNT_LSB +: 8] = fcnt_reg;
            rd_next[`QDAC_ST_ACNT_LSB +: 8] = acnt_reg;
         end
         `QDAC_CTRL_OFS: begin
            rd_next[`QDAC_CTRL_EN_BIT] = ctrl_view;
         end
         `QDAC_FRAME_OFS: begin
            rd_next[15:0] = last_frame_reg;
         end
         default: begin
            rd_next = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h0000_0000;
      end else if (ahb_take && !hwrite) begin
         rdata_reg <= rd_next;
      end
   end

   assign hrdata = rdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   applies_on_last_a: assert property (
      apply |-> (bit_cnt_reg == 4'hF) && sclk_fall && !fs_s2
   ) else $error("frame applied off its sixteenth edge");

   abort_keeps_a: assert property (
      abort |=> $stable(code_reg) && $stable(pd_reg) &&
         (state_reg == qdac_pkg::QDAC_ST_IDLE)
   ) else $error("aborted frame changed state");

   shift_needs_low_a: assert property (
      (state_reg == qdac_pkg::QDAC_ST_SHIFT) && $changed(state_reg) |->
         $past(fs_fall)
   ) else $error("shifting began without frame-select fall");

   shift_on_fall_a: assert property (
      (state_reg == qdac_pkg::QDAC_ST_SHIFT) && !sclk_fall |=>
         $stable(shreg_reg)
   ) else $error("shift register moved without a falling edge");

   one_chan_a: assert property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_ONE |=>
         code_reg[$past(frame_next.chan)] == $past(frame_next.code)
   ) else $error("single channel update lost");

   all_chan_a: assert property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_ALL |=>
         code_reg[0] == $past(frame_next.code) &&
         code_reg[3] == $past(frame_next.code)
   ) else $error("broadcast update incomplete");

   zero_until_write_a: assert property (
      !written_reg |-> code_reg == '0
   ) else $error("code nonzero before first frame");

   pd_term_a: assert property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_PD |=>
         pd_reg && term_reg != 2'h0
   ) else $error("power-down not applied");

   done_ignores_a: assert property (
      (state_reg == qdac_pkg::QDAC_ST_DONE) && !fs_s2 |=>
         (state_reg == qdac_pkg::QDAC_ST_DONE) && $stable(shreg_reg)
   ) else $error("edges taken after sixteenth bit");

   msb_first_a: assert property (
      apply |=> last_frame_reg[15:1] == $past(shreg_reg[14:0])
   ) else $error("frame not assembled msb first");

   cov_single_c: cover property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_ONE);
   cov_all_c: cover property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_ALL);
   cov_abort_c: cover property (abort);
   cov_pd_c: cover property (
      apply && frame_next.mode == qdac_pkg::QDAC_MODE_PD);

endmodule : qdac_serial_top

// [quad_dac_serial_frame_input_bench.sv]
// Self-checking bench of the quad DAC serial frame port
`timescale 1ns/1ps
`include "qdac_consts.svh"

module quad_dac_serial_frame_input_bench;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   wire hready;
   logic hreadyout, hresp, sclk, frame_sel_n, sdin;
   logic [31:0] hrdata, rd_data;
   logic [3:0][9:0] chan_code, exp_code;
   logic power_down, frame_applied;
   logic [1:0] term_sel;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int applied = 0;

   always #2.5 hclk = ~hclk;
   assign hready = hreadyout;

   qdac_serial_top #(.CHANNELS(4)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin),
      .chan_code(chan_code), .power_down(power_down),
      .term_sel(term_sel), .frame_applied(frame_applied)
   );

   qdac_host_model host (
      .sclk(sclk), .frame_sel_n(frame_sel_n), .sdin(sdin)
   );

   // ****************************************
   // Pulse counter and hang guard
   // ****************************************
   always @(posedge hclk) begin
      cycles++;
      if (frame_applied === 1'b1) begin
         applied++;
      end
      if (cycles == 20000) begin
         mismatches++;
         $display("[FAIL] %0t run stalled", $time);
         finish_test();
      end
   end

   task finish_test;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finish_test

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : check

   // One single transfer; waits on hready in both phases
   task ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, ofs};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd_data = hrdata;
   endtask : ahb

   task rd_chk(input logic [7:0] ofs, input logic [31:0] exp,
               input logic [31:0] mask);
      ahb(1'b0, ofs, 32'h0);
      check(rd_data & mask, exp);
   endtask : rd_chk

   function logic [15:0] fr(logic [1:0] ch, logic [1:0] m, logic [9:0] c,
                            logic [1:0] t);
      return {ch, m, c, t};
   endfunction : fr

   // Negative inc skips the pulse count
   task send_chk(input logic [15:0] f, input int n, input int inc);
      int a;
      a = applied;
      host.send(f, n);
      if (inc >= 0) begin
         check(32'(applied - a), 32'(inc));
      end
      for (int i = 0; i < 4; i++) begin
         check({22'h0, chan_code[i]}, {22'h0, exp_code[i]});
      end
   endtask : send_chk

   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      exp_code = '0;
      check({22'h0, chan_code[3]}, 32'h0);
      check({31'h0, power_down}, 32'h0);
      check({30'h0, term_sel}, {30'h0, `QDAC_TERM_RST});
      check({31'h0, hresp}, 32'h0);
      ahb(1'b1, `QDAC_CODE_AB_OFS, 32'hFFFFFFFF);
      rd_chk(`QDAC_CODE_AB_OFS, 32'h0, 32'hFFFFFFFF);
      rd_chk(`QDAC_CTRL_OFS, 32'h1, 32'h1);
      rd_chk(8'h20, 32'h0, 32'hFFFFFFFF);
   endtask : t_reset

   task t_single;
      for (int c = 0; c < 4; c++) begin
         exp_code[c] = 10'h201 + 10'(c * 3);
         send_chk(fr(2'(c), 2'h0, exp_code[c], 2'h0), 16, 1);
      end
      rd_chk(`QDAC_CODE_CD_OFS, 32'h020A0207, 32'hFFFFFFFF);
      exp_code = {4{10'h3FF}};
      send_chk(fr(2'h2, 2'h1, 10'h3FF, 2'h0), 16, 1);
   endtask : t_single

   task t_abort;
      send_chk(fr(2'h0, 2'h1, 10'h155, 2'h0), 15, 0);
      rd_chk(`QDAC_STATUS_OFS, 32'h00010000, 32'h00FF0000);
      exp_code[1] = 10'h2C1;
      send_chk(fr(2'h1, 2'h0, 10'h2C1, 2'h0), 20, 1);
      rd_chk(`QDAC_FRAME_OFS, {16'h0, fr(2'h1, 2'h0, 10'h2C1, 2'h0)},
             32'h0000FFFF);
   endtask : t_abort

   task t_pd;
      for (int t = 0; t < 4; t++) begin
         send_chk(fr(2'h0, 2'h2, 10'h3C3, 2'(t)), 16, 1);
         check({31'h0, power_down}, 32'h1);
         check({30'h0, term_sel}, (t == 0) ? 32'h3 : 32'(t));
      end
      send_chk(fr(2'h0, 2'h3, 10'h111, 2'h0), 16, 1);
      check({31'h0, power_down}, 32'h1);
      exp_code[3] = 10'h0F0;
      send_chk(fr(2'h3, 2'h0, 10'h0F0, 2'h0), 16, 1);
      check({31'h0, power_down}, 32'h0);
   endtask : t_pd

   task t_disable;
      ahb(1'b1, `QDAC_CTRL_OFS, 32'h0);
      rd_chk(`QDAC_CTRL_OFS, 32'h0, 32'h1);
      send_chk(fr(2'h0, 2'h1, 10'h2AA, 2'h0), 16, 0);
      ahb(1'b1, `QDAC_CTRL_OFS, 32'h1);
      exp_code = {4{10'h2AA}};
      send_chk(fr(2'h0, 2'h1, 10'h2AA, 2'h0), 16, 1);
      send_chk(fr(2'h0, 2'h1, 10'h2AA, 2'h0), 16, 1);
   endtask : t_disable

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      t_reset();
      t_single();
      t_abort();
      t_pd();
      t_disable();
      finish_test();
   end
endmodule : quad_dac_serial_frame_input_bench
